//--- hw/rofd_pkg.sv
package rofd_pkg;
  typedef logic [5:0]  rofd_fn_t;
  typedef logic [15:0] rofd_freq_t;
  typedef struct packed {
    logic run_active;
    logic trip_active;
  } rofd_status_s;
  typedef struct packed {
    logic [1:0] relay_r;
  } rofd_state_s;
endpackage

//--- hw/rofd_regs.svh
`ifndef ROFD_REGS_SVH
`define ROFD_REGS_SVH
`define ROFD_FN_NONE        6'h00
`define ROFD_FN_FREQ_REACH  6'h01
`define ROFD_FN_SET_MATCH   6'h02
`define ROFD_FN_OUT_MATCH   6'h03
`define ROFD_FN_RUN         6'h0E
`define ROFD_FN_TRIP        6'h1D
`define ROFD_FN_MAX         6'h2D
`define ROFD_R1_RST_FN      6'h1D
`define ROFD_R2_RST_FN      6'h0E
`define ROFD_DET_FREQ_RST   16'h0BB8
`define ROFD_DET_BAND_RST   16'h03E8
`define ROFD_HALF_SHIFT     4'h1
`define ROFD_RELAY_RST      2'h0
`endif

//--- hw/rofd_relay_out.sv
`timescale 1ns/1ns
`include "rofd_regs.svh"
// Summary of operation
// - Relay 1 follows a selectable function 0 to 45, trip code 29 after reset.
// - Relay 2 follows its own selectable function 0 to 45, run code 14 after reset.
// - A two-bit monitor shows the on or off state of both relays.
// - Detection modes share one detection frequency and one detection band.
// - Code 1 asserts while set minus output frequency magnitude is below half band.
// - Code 2 needs set frequency near detection frequency and the code 1 condition.
// - Code 3 asserts while output minus detection frequency magnitude is below half band.
module rofd_relay_out
  import rofd_pkg::*;
(
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         rstn,
  // Configuration; loaded when cfg_load is high.
  input  wire logic         cfg_load,
  input  wire rofd_fn_t     relay1_function_select,
  input  wire rofd_fn_t     relay2_function_select,
  input  wire rofd_freq_t   detect_frequency,
  input  wire rofd_freq_t   detect_band,
  // Drive state in 0.01 Hz units.
  input  wire rofd_freq_t   set_freq,
  input  wire rofd_freq_t   out_freq,
  input  wire rofd_status_s status,
  // Relays and monitor.
  output logic              relay1_on,
  output logic              relay2_on,
  output logic [1:0]        relay_state_monitor
);
  typedef struct packed {
    rofd_fn_t   fn1;
    rofd_fn_t   fn2;
    rofd_freq_t det_freq;
    rofd_freq_t det_band;
    logic [1:0] relay;
  } rofd_regs_s;

  rofd_regs_s st_r;
  rofd_regs_s st_nxt;
  logic       reach_hit;
  logic       set_hit;
  logic       out_hit;
  logic       dem1;
  logic       dem2;
  rofd_freq_t half_band;

  // Half the band is a right shift, so an odd band rounds down.
  function automatic logic near_hit(input rofd_freq_t a, input rofd_freq_t b,
                                    input rofd_freq_t band);
    rofd_freq_t diff;
    diff = (a > b) ? rofd_freq_t'(a - b) : rofd_freq_t'(b - a);
    near_hit = diff < (band >> `ROFD_HALF_SHIFT);
  endfunction

  // Codes above the range are refused so a bad load cannot select an unknown function.
  function automatic logic fn_legal(input rofd_fn_t fn);
    fn_legal = (fn <= `ROFD_FN_MAX);
  endfunction

  assign reach_hit = near_hit(set_freq, out_freq, st_r.det_band);
  assign set_hit   = near_hit(set_freq, st_r.det_freq, st_r.det_band);
  assign out_hit   = near_hit(out_freq, st_r.det_freq, st_r.det_band);
  assign half_band = st_r.det_band >> `ROFD_HALF_SHIFT;

  // Both relays see the same detection results and each picks by its own code.
  rofd_relay_sel u_sel1 (
    .fn_sel    (st_r.fn1),
    .reach_hit (reach_hit),
    .set_hit   (set_hit),
    .out_hit   (out_hit),
    .status    (status),
    .relay_on  (dem1)
  );

  rofd_relay_sel u_sel2 (
    .fn_sel    (st_r.fn2),
    .reach_hit (reach_hit),
    .set_hit   (set_hit),
    .out_hit   (out_hit),
    .status    (status),
    .relay_on  (dem2)
  );

  // Out-of-range function codes are refused and the previous selection is kept.
  always_comb
  begin
    st_nxt = st_r;
    if (cfg_load)
    begin
      if (fn_legal(relay1_function_select))
      begin
        st_nxt.fn1 = relay1_function_select;
      end
      if (fn_legal(relay2_function_select))
      begin
        st_nxt.fn2 = relay2_function_select;
      end
      st_nxt.det_freq = detect_frequency;
      st_nxt.det_band = detect_band;
    end
    st_nxt.relay = {dem2, dem1};
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_r.fn1      <= `ROFD_R1_RST_FN;
      st_r.fn2      <= `ROFD_R2_RST_FN;
      st_r.det_freq <= `ROFD_DET_FREQ_RST;
      st_r.det_band <= `ROFD_DET_BAND_RST;
      st_r.relay    <= `ROFD_RELAY_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign relay1_on           = st_r.relay[0];
  assign relay2_on           = st_r.relay[1];
  assign relay_state_monitor = st_r.relay;

  // Relays follow the stored function one edge after the inputs are sampled.
  relay1_trip_a: assert property (@(posedge clk) disable iff (!rstn)
    (st_r.fn1 == `ROFD_FN_TRIP) |=> (relay1_on == $past(status.trip_active)))
    else $error("relay1 trip mismatch");
  relay2_run_a: assert property (@(posedge clk) disable iff (!rstn)
    (st_r.fn2 == `ROFD_FN_RUN && $stable(st_r.fn2)) |=> (relay2_on == $past(status.run_active)))
    else $error("relay2 run mismatch");
  monitor_match_a: assert property (@(posedge clk) disable iff (!rstn)
    relay_state_monitor == {relay2_on, relay1_on})
    else $error("monitor differs from relays");
  fn_range_a: assert property (@(posedge clk) disable iff (!rstn)
    st_r.fn1 <= `ROFD_FN_MAX && st_r.fn2 <= `ROFD_FN_MAX)
    else $error("function code out of range");
  cfg_take_a: assert property (@(posedge clk) disable iff (!rstn)
    cfg_load |=> (st_r.det_band == $past(detect_band)))
    else $error("band not loaded");
  reach_mode_a: assert property (@(posedge clk) disable iff (!rstn)
    (st_r.fn1 == `ROFD_FN_FREQ_REACH && !cfg_load) |=> (relay1_on == $past(reach_hit)))
    else $error("reach mode wrong");
  set_mode_a: assert property (@(posedge clk) disable iff (!rstn)
    (st_r.fn1 == `ROFD_FN_SET_MATCH && !cfg_load) |=> (relay1_on == $past(set_hit && reach_hit)))
    else $error("set match mode wrong");
  out_mode_a: assert property (@(posedge clk) disable iff (!rstn)
    (st_r.fn2 == `ROFD_FN_OUT_MATCH && !cfg_load) |=> (relay2_on == $past(out_hit)))
    else $error("output match mode wrong");
  strict_cmp_a: assert property (@(posedge clk) disable iff (!rstn)
    (out_freq == st_r.det_freq + half_band) |-> !out_hit)
    else $error("comparison not strict");
  reach_mode2_a: assert property (@(posedge clk) disable iff (!rstn)
    (st_r.fn2 == `ROFD_FN_FREQ_REACH) |=> (relay2_on == $past(reach_hit)))
    else $error("relay2 reach mode wrong");
  set_mode2_a: assert property (@(posedge clk) disable iff (!rstn)
    (st_r.fn2 == `ROFD_FN_SET_MATCH) |=> (relay2_on == $past(set_hit && reach_hit)))
    else $error("relay2 set match mode wrong");
  out_mode1_a: assert property (@(posedge clk) disable iff (!rstn)
    (st_r.fn1 == `ROFD_FN_OUT_MATCH) |=> (relay1_on == $past(out_hit)))
    else $error("relay1 output match mode wrong");
  none_off1_a: assert property (@(posedge clk) disable iff (!rstn)
    (st_r.fn1 == `ROFD_FN_NONE) |=> !relay1_on)
    else $error("relay1 on with no function");
  none_off2_a: assert property (@(posedge clk) disable iff (!rstn)
    (st_r.fn2 == `ROFD_FN_NONE) |=> !relay2_on)
    else $error("relay2 on with no function");

  // Load steps: a legal code, a refused code, and a code 1 load followed by one edge.
  sequence fn1_ok_seq;
    cfg_load && fn_legal(relay1_function_select);
  endsequence
  sequence fn1_bad_seq;
    cfg_load && !fn_legal(relay1_function_select);
  endsequence
  sequence fn2_ok_seq;
    cfg_load && fn_legal(relay2_function_select);
  endsequence
  sequence fn2_bad_seq;
    cfg_load && !fn_legal(relay2_function_select);
  endsequence
  sequence reach_load_seq;
    (cfg_load && relay1_function_select == `ROFD_FN_FREQ_REACH) ##1 1'b1;
  endsequence

  fn1_load_a: assert property (@(posedge clk) disable iff (!rstn)
    fn1_ok_seq |=> (st_r.fn1 == $past(relay1_function_select)))
    else $error("relay1 code not loaded");
  fn1_keep_a: assert property (@(posedge clk) disable iff (!rstn)
    fn1_bad_seq |=> $stable(st_r.fn1))
    else $error("refused relay1 code stored");
  fn2_load_a: assert property (@(posedge clk) disable iff (!rstn)
    fn2_ok_seq |=> (st_r.fn2 == $past(relay2_function_select)))
    else $error("relay2 code not loaded");
  fn2_keep_a: assert property (@(posedge clk) disable iff (!rstn)
    fn2_bad_seq |=> $stable(st_r.fn2))
    else $error("refused relay2 code stored");
  freq_take_a: assert property (@(posedge clk) disable iff (!rstn)
    cfg_load |=> (st_r.det_freq == $past(detect_frequency)))
    else $error("frequency not loaded");
  cfg_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    !cfg_load |=> ($stable(st_r.det_freq) && $stable(st_r.det_band)))
    else $error("setup changed without load");
  // A new code 1 reaches relay 1 on the second edge after its load.
  reach_load_a: assert property (@(posedge clk) disable iff (!rstn)
    reach_load_seq |=> (relay1_on == $past(reach_hit)))
    else $error("code 1 load not applied");

  // A difference of exactly half the band lies outside the window.
  reach_strict_a: assert property (@(posedge clk) disable iff (!rstn)
    (out_freq == set_freq + half_band) |-> !reach_hit)
    else $error("reach comparison not strict");
  set_strict_a: assert property (@(posedge clk) disable iff (!rstn)
    (set_freq + half_band == st_r.det_freq) |-> !set_hit)
    else $error("set comparison not strict");

  // Reset leaves relay 1 on trip, relay 2 on run and both relays off.
  reset_dflt_a: assert property (@(posedge clk)
    $rose(rstn) |-> (st_r.fn1 == `ROFD_R1_RST_FN && st_r.fn2 == `ROFD_R2_RST_FN
                     && st_r.relay == `ROFD_RELAY_RST))
    else $error("reset defaults wrong");
endmodule

//--- hw/rofd_relay_sel.sv
`timescale 1ns/1ns
`include "rofd_regs.svh"
module rofd_relay_sel
  import rofd_pkg::*;
(
  // Function select and detect results.
  input  wire rofd_fn_t     fn_sel,
  input  wire logic         reach_hit,
  input  wire logic         set_hit,
  input  wire logic         out_hit,
  input  wire rofd_status_s status,
  // Relay demand.
  output logic              relay_on
);
  always_comb
  begin
    case (fn_sel)
      `ROFD_FN_FREQ_REACH: relay_on = reach_hit;
      `ROFD_FN_SET_MATCH:  relay_on = set_hit & reach_hit;
      `ROFD_FN_OUT_MATCH:  relay_on = out_hit;
      `ROFD_FN_RUN:        relay_on = status.run_active;
      `ROFD_FN_TRIP:       relay_on = status.trip_active;
      default:             relay_on = 1'b0;
    endcase
  end
endmodule

//--- verif/rofd_relay_contacts.sv
`timescale 1ns/1ns
module rofd_relay_contacts
(
  // Relay coils.
  input  wire logic       coil1,
  input  wire logic       coil2,
  // Contact state seen by the control equipment.
  output logic [1:0]      closed
);
  assign closed = {coil2, coil1};
endmodule

//--- verif/tb.sv
`timescale 1ns/1ns
`include "rofd_regs.svh"
module tb import rofd_pkg::*;;
  logic         clk, rstn, cfg_load, r1, r2;
  rofd_fn_t     fs1, fs2, m1, m2;
  rofd_freq_t   det, band, sf, of, md, mb;
  rofd_status_s st;
  logic [1:0]   mon, cont, exp;
  int           bad_count, checked;
  rofd_fn_t     codes [8] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h0E, 6'h1D, 6'h2D, 6'h2E};
  rofd_relay_out uut (.clk(clk), .rstn(rstn), .cfg_load(cfg_load),
    .relay1_function_select(fs1), .relay2_function_select(fs2),
    .detect_frequency(det), .detect_band(band), .set_freq(sf), .out_freq(of),
    .status(st), .relay1_on(r1), .relay2_on(r2), .relay_state_monitor(mon));
  rofd_relay_contacts far (.coil1(r1), .coil2(r2), .closed(cont));
  function automatic logic fexp(rofd_fn_t f);
    logic [15:0] h;
    logic        reach;
    h = mb >> 1;
    reach = ((sf > of) ? sf - of : of - sf) < h;
    case (f)
      6'h01: return reach;
      6'h02: return (((sf > md) ? sf - md : md - sf) < h) && reach;
      6'h03: return ((of > md) ? of - md : md - of) < h;
      6'h0E: return st.run_active;
      6'h1D: return st.trip_active;
      default: return 1'b0;
    endcase
  endfunction
  task automatic chk(logic [1:0] got, logic [1:0] want);
    checked++;
    if (got !== want)
    begin
      bad_count++;
      $display("wrong value at %0t: got %b want %b", $time, got, want);
    end
  endtask
  task automatic finish_test();
    if (bad_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Holds reset for two edges, checks that both relays are off, then releases it.
  task automatic apply_reset();
    rstn = 0;
    m1 = `ROFD_R1_RST_FN;
    m2 = `ROFD_R2_RST_FN;
    md = `ROFD_DET_FREQ_RST;
    mb = `ROFD_DET_BAND_RST;
    repeat (2) @(posedge clk);
    #1;
    chk({r2, r1}, 2'b00);
    chk(mon, 2'b00);
    rstn = 1;
  endtask
  // The edge evaluates with the stored setup; a load takes effect one edge later.
  task automatic step();
    @(posedge clk);
    exp = {fexp(m2), fexp(m1)};
    if (cfg_load)
    begin
      if (fs1 <= 6'h2D) m1 = fs1;
      if (fs2 <= 6'h2D) m2 = fs2;
      md = det;
      mb = band;
    end
    #1;
    chk({r2, r1}, exp);
    chk(mon, exp);
    chk(cont, exp);
  endtask
  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    #50000;
    bad_count++;
    finish_test();
  end
  initial
  begin
    {cfg_load, fs1, fs2, det, band, sf, of, st} = '0;
    void'($urandom(74));
    apply_reset();
    for (int i = 0; i < 2000; i++)
    begin
      // A reset in mid-run must bring back the default setup.
      if (i == 1000)
        apply_reset();
      cfg_load = (i > 6) && ($urandom_range(0, 3) == 0);
      fs1 = codes[$urandom_range(0, 7)];
      fs2 = codes[$urandom_range(0, 7)];
      det = 16'($urandom_range(2500, 3500));
      band = 16'($urandom_range(0, 2000));
      sf = 16'($urandom_range(2000, 4000));
      of = sf + 16'($urandom_range(0, 1200)) - 16'h0258;
      st = 2'($urandom);
      // A difference of exactly half the band must not count as a hit.
      if (i % 4 == 0)
        of = sf + (mb >> 1);
      if (i % 4 == 1)
        of = md + (mb >> 1);
      if (i % 4 == 2)
        sf = md - (mb >> 1);
      step();
    end
    finish_test();
  end
endmodule
